// [assoc_pkg.sv]
package assoc_pkg;
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned ID_W            = 32;
	localparam int unsigned LIST_DEPTH      = 60;
	localparam int unsigned SLOT_W          = 6;
	localparam int unsigned MODE_W          = 3;
	localparam int unsigned LEARN_HOLD_MS   = 20;
	localparam int unsigned LEARN_WIN_MS    = 10_000;
	localparam int unsigned CLEAR_HOLD_MS   = 10_000;
	localparam int unsigned CLEAR_SIG_MS    = 3_000;
	localparam int unsigned BLINK_MS        = 50;
	localparam int unsigned WAKE_MS         = 3;
	localparam int unsigned LEARN_HOLD_CYC  = LEARN_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned LEARN_WIN_CYC   = LEARN_WIN_MS * (CLK_HZ / 1000);
	localparam int unsigned CLEAR_HOLD_CYC  = CLEAR_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned CLEAR_SIG_CYC   = CLEAR_SIG_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_CYC       = BLINK_MS * (CLK_HZ / 1000);
	localparam int unsigned WAKE_CYC        = WAKE_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_TOGGLES   = 6;
	localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
	localparam logic [31:0] SELF_ID_DEFAULT  = 32'h1234ABCD; // value arbitrary

	typedef enum logic [2:0] {
		ST_WAKE  = 3'b000,
		ST_IDLE  = 3'b001,
		ST_LEARN = 3'b011,
		ST_BLINK = 3'b010,
		ST_LOW   = 3'b110,
		ST_CLRSG = 3'b111
	} learn_state_e;

	typedef struct packed {
		logic            valid;
		logic [ID_W-1:0] sender;
		logic [7:0]      data;
	} rx_pkt_s;

	typedef struct packed {
		logic            valid;
		logic [ID_W-1:0] sender;
		logic [7:0]      data;
	} tx_pkt_s;

	function automatic logic mode_is_network(input logic [MODE_W-1:0] m);
		return (m == 3'h3) || (m == 3'h5) || (m == 3'h7);
	endfunction
endpackage

// [network_association_learner.sv]
// Operation
// - own 32-bit identifier is fixed at build time, never writable.
// - every outgoing packet carries own identifier in its sender field.
// - in network modes, received payloads pass only from associated senders.
// - learn pin high at least 20 ms then low enters learning.
// - during learning the learn pin is driven high as an output.
// - first packet during learning stores its sender; its payload is dropped.
// - after a learn, pin blinks on and off three times.
// - learning ends on any received packet or 10 s timeout; pin low, then input.
// - list holds up to 60 distinct identifiers.
// - no single-entry removal; only whole-list clear exists.
// - learn pin high at least 10 s then released clears the list.
// - after clear, pin alternates fast for a few seconds.
// - with entries stored, only stored senders' payloads are accepted.
// - network mode with empty list passes no received payloads.
// - learn procedure works only in modes 3, 5 and 7.
// - active-low reset restarts and re-samples the three mode pins.
// - mode pins are sampled once after reset, later changes ignored.
// - ready for traffic 3 ms after reset release.
`timescale 1ns/10ps
module network_association_learner #(
	parameter logic [31:0] SELF_ID     = assoc_pkg::SELF_ID_DEFAULT, // value arbitrary
	parameter int unsigned HOLD_CYC    = assoc_pkg::LEARN_HOLD_CYC,
	parameter int unsigned WIN_CYC     = assoc_pkg::LEARN_WIN_CYC,
	parameter int unsigned CLRH_CYC    = assoc_pkg::CLEAR_HOLD_CYC,
	parameter int unsigned CLRS_CYC    = assoc_pkg::CLEAR_SIG_CYC,
	parameter int unsigned BLNK_CYC    = assoc_pkg::BLINK_CYC,
	parameter int unsigned WK_CYC      = assoc_pkg::WAKE_CYC,
	parameter int unsigned DEPTH       = assoc_pkg::LIST_DEPTH
) (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic [assoc_pkg::MODE_W-1:0]  mode_sel,
	input  wire logic                          learn_in,
	output logic                               learn_out,
	output logic                               learn_oe,
	input  wire assoc_pkg::rx_pkt_s            rx_pkt,
	output assoc_pkg::rx_pkt_s                 rx_acc,
	input  wire assoc_pkg::tx_pkt_s            tx_pkt,
	output assoc_pkg::tx_pkt_s                 tx_out,
	output logic                               ready,
	output logic [assoc_pkg::MODE_W-1:0]       mode_active,
	output logic [assoc_pkg::SLOT_W-1:0]       list_count
);
	import assoc_pkg::*;

	// elaboration check: slot counter is 6 bits, every span needs at least one cycle
	if (DEPTH < 1 || DEPTH > 63 || HOLD_CYC < 1 || WIN_CYC < 1 || CLRH_CYC <= HOLD_CYC
		|| CLRS_CYC < 1 || BLNK_CYC < 1 || WK_CYC < 1) begin : g_bad_param
		$error("network_association_learner: unsupported parameter values");
	end

	logic                  pin_s1_reg;
	logic                  pin_s2_reg;
	logic [MODE_W-1:0]     mode_s1_reg;
	logic [MODE_W-1:0]     mode_s2_reg;
	logic                  sampled_reg;
	logic [MODE_W-1:0]     mode_reg;
	learn_state_e          state_reg;
	learn_state_e          state_next;
	logic [31:0]           timer_reg;
	logic [31:0]           timer_next;
	logic [31:0]           hold_reg;
	logic [2:0]            blink_reg;
	logic [2:0]            blink_next;
	logic [ID_W-1:0]       list_mem [DEPTH];
	logic [DEPTH-1:0]      used_reg;
	logic [SLOT_W-1:0]     count_reg;
	logic                  out_reg;
	logic                  oe_reg;
	logic                  out_next;
	logic                  oe_next;
	logic                  ready_reg;
	rx_pkt_s               rx_reg;
	tx_pkt_s               tx_reg;

	wire                   net_mode   = mode_is_network(mode_reg);
	wire                   idle_pin   = (state_reg == ST_IDLE) && net_mode;
	wire                   pin_fall   = idle_pin && !pin_s2_reg && (hold_reg != 32'h0);
	wire                   go_learn   = pin_fall && (hold_reg >= HOLD_CYC) && (hold_reg < CLRH_CYC);
	wire                   go_clear   = pin_fall && (hold_reg >= CLRH_CYC);
	wire [DEPTH-1:0]       hit_vec;
	wire                   hit        = |hit_vec;
	wire                   full       = (count_reg == SLOT_W'(DEPTH));
	wire                   learn_pkt  = (state_reg == ST_LEARN) && rx_pkt.valid;
	wire                   store_new  = learn_pkt && !hit && !full;
	wire                   pass_rx    = ready_reg && rx_pkt.valid && (state_reg != ST_LEARN)
		&& (!net_mode || hit);
	wire                   timer_done = (timer_reg == 32'h0);

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_match
			assign hit_vec[gi] = used_reg[gi] && (list_mem[gi] == rx_pkt.sender);
		end
	endgenerate

	function automatic logic [SLOT_W-1:0] first_free(input logic [DEPTH-1:0] u);
		logic [SLOT_W-1:0] idx;
		idx = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (!u[i])
				idx = SLOT_W'(i);
		end
		return idx;
	endfunction

	wire [SLOT_W-1:0]      free_slot = first_free(used_reg);

	always_ff @(posedge clk) begin
		pin_s1_reg  <= learn_in;
		pin_s2_reg  <= pin_s1_reg;
		mode_s1_reg <= mode_sel;
		mode_s2_reg <= mode_s1_reg;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sampled_reg <= 1'b0;
			mode_reg    <= MODE_RESET;
		end else if (!sampled_reg && state_reg == ST_WAKE && timer_reg == WK_CYC - 1) begin
			sampled_reg <= 1'b1;
			mode_reg    <= mode_s2_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			hold_reg <= 32'h0;
		else if (!idle_pin || !pin_s2_reg)
			hold_reg <= 32'h0;
		else if (hold_reg != 32'hFFFFFFFF)
			hold_reg <= hold_reg + 32'h1;
	end

	always_comb begin
		state_next = state_reg;
		timer_next = timer_done ? 32'h0 : timer_reg - 32'h1;
		blink_next = blink_reg;
		out_next   = out_reg;
		oe_next    = oe_reg;
		case (state_reg)
			ST_WAKE: begin
				if (timer_done) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				oe_next  = 1'b0;
				out_next = 1'b0;
				if (go_learn) begin
					state_next = ST_LEARN;
					timer_next = WIN_CYC - 1;
					oe_next    = 1'b1;
					out_next   = 1'b1;
				end else if (go_clear) begin
					state_next = ST_CLRSG;
					timer_next = CLRS_CYC - 1;
					blink_next = 3'h0;
					oe_next    = 1'b1;
					out_next   = 1'b1;
				end
			end
			ST_LEARN: begin
				if (learn_pkt && !full | hit) begin
					state_next = ST_BLINK;
					timer_next = BLNK_CYC - 1;
					blink_next = 3'h0;
					out_next   = 1'b0;
				end else if (learn_pkt || timer_done) begin
					state_next = ST_LOW;
					out_next   = 1'b0;
				end
			end
			ST_BLINK: begin
				if (timer_done) begin
					timer_next = BLNK_CYC - 1;
					if (blink_reg == 3'(BLINK_TOGGLES - 1)) begin
						state_next = ST_LOW;
						out_next   = 1'b0;
					end else begin
						blink_next = blink_reg + 3'h1;
						out_next   = !out_reg;
					end
				end
			end
			ST_LOW: begin
				state_next = ST_IDLE;
				oe_next    = 1'b0;
			end
			ST_CLRSG: begin
				if (timer_done) begin
					state_next = ST_LOW;
					out_next   = 1'b0;
				end else begin
					out_next   = !out_reg;
				end
			end
			default: begin
				state_next = ST_IDLE;
				oe_next    = 1'b0;
				out_next   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= ST_WAKE;
			timer_reg <= WK_CYC;
			blink_reg <= 3'h0;
			out_reg   <= 1'b0;
			oe_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			blink_reg <= blink_next;
			out_reg   <= out_next;
			oe_reg    <= oe_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			used_reg  <= '0;
			count_reg <= '0;
		end else if (go_clear) begin
			used_reg  <= '0;
			count_reg <= '0;
		end else if (store_new) begin
			used_reg[free_slot] <= 1'b1;
			count_reg           <= count_reg + SLOT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (store_new)
			list_mem[free_slot] <= rx_pkt.sender;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ready_reg <= 1'b0;
			rx_reg    <= '0;
			tx_reg    <= '0;
		end else begin
			ready_reg     <= (state_next != ST_WAKE);
			rx_reg        <= pass_rx ? rx_pkt : '0;
			tx_reg.valid  <= ready_reg && tx_pkt.valid;
			tx_reg.data   <= tx_pkt.data;
			tx_reg.sender <= SELF_ID;
		end
	end

	assign learn_out   = out_reg;
	assign learn_oe    = oe_reg;
	assign rx_acc      = rx_reg;
	assign tx_out      = tx_reg;
	assign ready       = ready_reg;
	assign mode_active = mode_reg;
	assign list_count  = count_reg;

	a_tx_sender: assert property (@(posedge clk) disable iff (!nrst)
		tx_out.valid |-> tx_out.sender == SELF_ID)
		else $error("tx sender not own id");
	a_learn_drive: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_LEARN |-> learn_oe && learn_out)
		else $error("learn pin not high");
	a_learn_drop: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_LEARN |=> !rx_acc.valid)
		else $error("learn payload passed");
	a_empty_mute: assert property (@(posedge clk) disable iff (!nrst)
		net_mode && count_reg == '0 && state_reg != ST_LEARN |=> !rx_acc.valid)
		else $error("empty list passed data");
	a_list_bound: assert property (@(posedge clk) disable iff (!nrst)
		list_count <= SLOT_W'(DEPTH))
		else $error("list overflow");
	a_store_count: assert property (@(posedge clk) disable iff (!nrst)
		store_new |=> list_count == $past(list_count) + SLOT_W'(1))
		else $error("new id did not take one slot");
	a_dup_slot: assert property (@(posedge clk) disable iff (!nrst)
		learn_pkt && hit |=> $stable(list_count))
		else $error("duplicate took slot");
	a_full_exit: assert property (@(posedge clk) disable iff (!nrst)
		learn_pkt && full && !hit |=> state_reg == ST_LOW ##1 !learn_oe)
		else $error("full exit wrong");
	a_mode_hold: assert property (@(posedge clk) disable iff (!nrst)
		sampled_reg |=> $stable(mode_active))
		else $error("mode changed");
	a_low_exit: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_LOW |-> !learn_out ##1 !learn_oe)
		else $error("exit not low then input");
	a_non_net: assert property (@(posedge clk) disable iff (!nrst)
		!net_mode |-> state_reg inside {ST_WAKE, ST_IDLE})
		else $error("learn outside network mode");
	a_clear_empty: assert property (@(posedge clk) disable iff (!nrst)
		go_clear |=> list_count == '0)
		else $error("list not erased");
	a_clear_toggle: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_CLRSG && !timer_done |=> learn_out != $past(learn_out))
		else $error("clear pattern not alternating");
	a_wake_quiet: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == ST_WAKE |-> !ready && !learn_oe)
		else $error("active before wake time over");
endmodule // network_association_learner

// [far_side.sv]
`timescale 1ns/10ps
module far_side (
	input  wire logic         clk,
	output assoc_pkg::rx_pkt_s rx_pkt,
	output logic              host_hi
);
	import assoc_pkg::*;
	initial begin
		rx_pkt = '0;
		host_hi = 1'b0;
	end
	// one packet per call; the lines carry scrambled values between packets
	task automatic send(input logic [31:0] id, input logic [7:0] d);
		@(negedge clk);
		rx_pkt = '{1'b1, id, d};
		@(negedge clk);
		rx_pkt = '{1'b0, ~id, ~d};
	endtask
	// host presses the pin for n cycles, then the pull-down takes it low
	task automatic hold(input int n);
		@(negedge clk);
		host_hi = 1'b1;
		repeat (n) @(negedge clk);
		host_hi = 1'b0;
	endtask
endmodule // far_side

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	import assoc_pkg::*;
	localparam int          WIN  = 500;
	localparam int          WK   = 10;
	logic              clk;
	logic              nrst;
	logic [MODE_W-1:0] mode_sel;
	logic              learn_out;
	logic              learn_oe;
	logic              host_hi;
	logic              pin;
	logic              tail;
	rx_pkt_s           rx_pkt;
	rx_pkt_s           rx_acc;
	tx_pkt_s           tx_pkt;
	tx_pkt_s           tx_out;
	logic              ready;
	logic [MODE_W-1:0] mode_active;
	logic [SLOT_W-1:0] list_count;
	int                n_fail;
	int                n_compared;
	int                rises;
	int                len;
	assign pin = learn_oe ? learn_out : host_hi;
	network_association_learner #(.HOLD_CYC(20), .WIN_CYC(WIN), .CLRH_CYC(200), .CLRS_CYC(50), .BLNK_CYC(5),
		.WK_CYC(WK)) i_network_association_learner (.clk(clk), .nrst(nrst),
		.mode_sel(mode_sel), .learn_in(pin), .learn_out(learn_out), .learn_oe(learn_oe), .rx_pkt(rx_pkt),
		.rx_acc(rx_acc), .tx_pkt(tx_pkt), .tx_out(tx_out), .ready(ready), .mode_active(mode_active),
		.list_count(list_count));
	far_side i_far_side (.clk(clk), .rx_pkt(rx_pkt), .host_hi(host_hi));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic [2:0] m);
		int n;
		n = 0;
		@(negedge clk);
		nrst = 1'b0;
		mode_sel = m;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		while (ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		chk("wake", 32'h1, 32'(n >= WK && n <= WK + 2));
		chk("mode", 32'(m), 32'(mode_active));
		chk("count", 32'h0, 32'(list_count));
	endtask
	task automatic wait_oe();
		int n;
		n = 0;
		while (learn_oe !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		chk("pin", 32'h1, 32'(pin));
	endtask
	// follows the pin until the device lets go of it
	task automatic watch();
		logic last;
		rises = 0;
		len = 0;
		last = pin;
		while (learn_oe === 1'b1 && len < 2000) begin
			tail = pin;
			@(negedge clk);
			if (pin === 1'b1 && last === 1'b0)
				rises++;
			last = pin;
			len++;
		end
	endtask
	task automatic teach(input logic [31:0] id, input logic snd);
		i_far_side.hold(25);
		wait_oe();
		if (snd) begin
			i_far_side.send(id, 8'hA5);
			chk("drop", 32'h0, 32'(rx_acc.valid));
		end
		watch();
		chk("tail", 32'h0, 32'(tail));
	endtask
	task automatic expect_rx(input logic [31:0] id, input logic v);
		i_far_side.send(id, 8'h3C);
		chk("rx valid", 32'(v), 32'(rx_acc.valid));
		if (v) begin
			chk("rx data", 32'h3C, 32'(rx_acc.data));
			chk("rx sender", id, rx_acc.sender);
		end
	endtask
	task automatic t_boot();
		do_reset(3'h3);
		mode_sel = 3'h0;
		repeat (20) @(negedge clk);
		chk("mode kept", 32'h3, 32'(mode_active));
		tx_pkt = '{1'b1, 32'h0, 8'h96};
		@(negedge clk);
		tx_pkt = '{1'b0, 32'hFFFFFFFF, 8'h69};
		chk("tx valid", 32'h1, 32'(tx_out.valid));
		chk("tx sender", SELF_ID_DEFAULT, tx_out.sender);
		chk("tx data", 32'h96, 32'(tx_out.data));
		@(negedge clk);
		chk("tx pulse", 32'h0, 32'(tx_out.valid));
		expect_rx(32'h77, 1'b0);
		$display("boot done");
	endtask
	task automatic t_learn();
		teach(32'h100, 1'b1);
		chk("blinks", 32'h3, 32'(rises));
		chk("count", 32'h1, 32'(list_count));
		expect_rx(32'h100, 1'b1);
		expect_rx(32'h200, 1'b0);
		teach(32'h100, 1'b1);
		chk("dup blinks", 32'h3, 32'(rises));
		chk("dup count", 32'h1, 32'(list_count));
		teach(32'h0, 1'b0);
		chk("idle blinks", 32'h0, 32'(rises));
		chk("window", 32'h1, 32'(len >= WIN - 10 && len <= WIN + 5));
		$display("learn done");
	endtask
	task automatic t_full();
		for (int i = 1; i < LIST_DEPTH; i++)
			teach(32'h100 + 32'(i), 1'b1);
		chk("full count", 32'(LIST_DEPTH), 32'(list_count));
		teach(32'h999, 1'b1);
		chk("full blinks", 32'h0, 32'(rises));
		chk("full kept", 32'(LIST_DEPTH), 32'(list_count));
		expect_rx(32'h13B, 1'b1);
		$display("full done");
	endtask
	task automatic t_clear();
		i_far_side.hold(210);
		wait_oe();
		watch();
		chk("cleared", 32'h0, 32'(list_count));
		chk("fast", 32'h1, 32'(rises >= 10));
		chk("clear len", 32'h1, 32'(len >= 45 && len <= 55));
		expect_rx(32'h100, 1'b0);
		$display("clear done");
	endtask
	task automatic t_plain();
		do_reset(3'h7);
		teach(32'h300, 1'b1);
		chk("mode 7 count", 32'h1, 32'(list_count));
		do_reset(3'h5);
		teach(32'h400, 1'b1);
		chk("mode 5 blinks", 32'h3, 32'(rises));
		expect_rx(32'h300, 1'b0);
		do_reset(3'h0);
		expect_rx(32'h200, 1'b1);
		i_far_side.hold(25);
		repeat (10) @(negedge clk);
		chk("no learn", 32'h0, 32'(learn_oe));
		$display("plain done");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300000;
		n_fail++;
		wrap_up();
	end
	initial begin
		n_fail = 0;
		n_compared = 0;
		nrst = 1'b0;
		mode_sel = 3'h0;
		tx_pkt = '0;
		tail = 1'b0;
		t_boot();
		t_learn();
		t_full();
		t_clear();
		t_plain();
		wrap_up();
	end
endmodule // tb_top
